// ### test/ir_transceiver_model.sv
// Infrared transceiver model: times light pulses and flashes the receiver
`default_nettype none

module ir_transceiver_model (
	input wire logic core_clk, // Time base
	input wire logic txLight, // Emitter drive, high is light
	output logic rxLight // Detector output, high is light
);
	timeunit 1ns;
	timeprecision 1ns;
	int pulseCount = 0;
	int lastWidth = 0;
	int runLen = 0;
	initial rxLight = 1'b0;
	// Count each light pulse and keep its width in core cycles
	always @(posedge core_clk)
	begin
		if (txLight === 1'b1)
			runLen <= runLen + 1;
		else if (runLen != 0)
		begin
			pulseCount <= pulseCount + 1;
			lastWidth <= runLen;
			runLen <= 0;
		end
	end
	// Light for n cycles, then dark; no light means a low output
	task automatic flash(input int n);
		rxLight <= 1'b1;
		repeat (n) @(posedge core_clk);
		rxLight <= 1'b0;
	endtask
endmodule // ir_transceiver_model

`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the infrared pulse shaper
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import infrared_shaper_pkg::*;
	logic core_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic serialPortTx, serialPortRx, uartBTransmitPin, uartBReceivePin;
	logic baudTick16 = 1'b0;
	logic [APB_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	int nErrors = 0;
	int comparisons = 0;
	int cycles = 0;
	int tickCnt = 0;
	int tickPeriod = 8;
	logic [31:0] prdataDummy;
	logic errDummy;
	// Shaping passes: mode, tick period, frame, pulse count, width window
	localparam logic MODE [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	localparam int TPER [4] = '{8, 4, 8, 12};
	localparam logic [7:0] FRAME [4] = '{8'h00, 8'h55, 8'hFF, 8'h55};
	localparam int NPULSE [4] = '{9, 5, 1, 5};
	localparam int WLO [4] = '{15, 15, 16, 24};
	localparam int WHI [4] = '{17, 17, 27, 39};

	infrared_pulse_shaper i_dut (
		.core_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .baudTick16, .serialPortTx, .serialPortRx,
		.uartBTransmitPin, .uartBReceivePin
	);
	ir_transceiver_model i_ir (.core_clk, .txLight(uartBTransmitPin), .rxLight(uartBReceivePin));

	////////////////////////////////////////////////////////////
	// Clock, 100 ns period
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// 16x tick as either baud timer would make it, shared by both directions
	always @(posedge core_clk)
	begin
		tickCnt <= (tickCnt >= tickPeriod - 1) ? 0 : tickCnt + 1;
		baudTick16 <= (tickCnt >= tickPeriod - 1);
	end
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			nErrors = nErrors + 1;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", nErrors, comparisons);
		if (nErrors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check8(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			nErrors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic checkRange(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi)
		begin
			nErrors++;
			$display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [7:0] wd,
		input logic [3:0] st, output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, wd};
		pstrb <= st;
		@(posedge core_clk);
		penable <= 1'b1;
		// Wait states are the slave's call; only the hang guard ends a stuck wait
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic regWrite(input logic [APB_ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, 4'hF, r, e);
	endtask
	task automatic regRead(input logic [APB_ADDR_W-1:0] a, input logic [31:0] exp,
		input logic expErr);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 8'h00, 4'hF, d, e);
		check8(d, exp);
		check8({31'h0, e}, {31'h0, expErr});
	endtask
	// Start, eight data bits, stop; each change lands with a tick
	task automatic sendFrame(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		do @(posedge core_clk); while (tickCnt < tickPeriod - 1);
		for (int i = 0; i < 10; i++)
		begin
			serialPortTx <= f[i];
			repeat (16 * tickPeriod) @(posedge core_clk);
		end
	endtask

	////////////////////////////////////////////////////////////
	// Out of reset the paths pass straight through
	task automatic testBypass();
		@(posedge core_clk);
		serialPortTx <= 1'b0;
		repeat (2) @(posedge core_clk);
		check8({31'h0, uartBTransmitPin}, 32'h0);
		serialPortTx <= 1'b1;
		repeat (2) @(posedge core_clk);
		check8({31'h0, uartBTransmitPin}, 32'h1);
		fork
			i_ir.flash(10);
		join_none
		repeat (6) @(posedge core_clk);
		check8({31'h0, serialPortRx}, 32'h1);
		repeat (10) @(posedge core_clk);
		check8({31'h0, serialPortRx}, 32'h0);
	endtask
	// Reset values, reserved bit, clamped code, strobes, unmapped place
	task automatic testRegisters();
		regRead(CTRL_ADDR, 32'h0F, 1'b0);
		regRead(BAUD_ADDR, 32'h00, 1'b0);
		regWrite(CTRL_ADDR, 8'hFF);
		regRead(CTRL_ADDR, 32'h7F, 1'b0);
		apb(1'b1, CTRL_ADDR, 8'h0F, 4'h0, prdataDummy, errDummy);
		regRead(CTRL_ADDR, 32'h7F, 1'b0);
		regWrite(CTRL_ADDR, 8'h0F);
		regRead(CTRL_ADDR, 32'h0F, 1'b0);
		for (int c = 0; c < 16; c++)
		begin
			regWrite(BAUD_ADDR, {c[3:0], 4'h0});
			regRead(BAUD_ADDR, {24'h0, (c > 12) ? 4'hC : c[3:0], 4'h0}, 1'b0);
		end
		regWrite(12'h000, 8'h55);
		regRead(12'h000, 32'h0, 1'b1);
	endtask
	// Zero bits become short pulses, ones none; widths per mode and rate
	task automatic testTxShaping();
		int base;
		for (int i = 0; i < 4; i++)
		begin
			tickPeriod = TPER[i];
			regWrite(CTRL_ADDR, {2'b01, MODE[i], 5'h05});
			repeat (20) @(posedge core_clk);
			base = i_ir.pulseCount;
			sendFrame(FRAME[i]);
			repeat (4) @(posedge core_clk);
			checkRange(i_ir.pulseCount - base, NPULSE[i], NPULSE[i]);
			checkRange(i_ir.lastWidth, WLO[i], WHI[i]);
		end
	endtask
	// A short flash holds the receive line low for one bit time
	task automatic testRxStretch();
		int n;
		tickPeriod = 8;
		regWrite(CTRL_ADDR, 8'h45);
		repeat (20) @(posedge core_clk);
		check8({31'h0, serialPortRx}, 32'h1);
		fork
			i_ir.flash(16);
		join_none
		n = 0;
		while (serialPortRx !== 1'b0 && n < 10)
		begin
			@(posedge core_clk);
			n++;
		end
		checkRange(n, 2, 6);
		n = 0;
		while (serialPortRx === 1'b0 && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		checkRange(n, 118, 132);
	endtask

	////////////////////////////////////////////////////////////
	// Reset for five cycles, then the scenarios
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		serialPortTx = 1'b1;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		testBypass();
		testRegisters();
		testTxShaping();
		testRxStretch();
		print_verdict();
	end
endmodule // tb_top

`default_nettype wire

// ### verilog/infrared_pulse_shaper.sv
// Infrared pulse shaper between the second serial port and its pins, APB slave
//
// Design decision made here: register access over APB.
`default_nettype none

// Operation
// - Enabled: each transmitted zero bit becomes one short high pulse on the pin.
// - Enabled: one bits, stop bits and idle produce no pulse.
// - Enabled: received short pulses are widened so the receiver sees a zero.
// - Shaping is off after reset; the enable bit (bit 6) turns it on.
// - Disabled: transmit and receive pass straight through, unmodified.
// - Enabled: shaping sits in both paths, plain port outputs disconnected.
// - Bit timing comes from the port's 16x tick, whichever timer makes it.
// - Pulse-mode bit 5: zero gives fixed width, one gives proportional width.
// - Proportional pulses last three sixteenths of a bit period.
// - Fixed pulses have one width at every baud, timed from the reference clock.
// - Reference clock is the core clock divided by the five-bit divider field.
// - Divider resets to 0Fh; the control register reads 0Fh after reset.
// - Pulses are never shorter than 1.41 us; the 2.23 us maximum at 115.2k is not enforced and rests on the divider choice.
// - A four-bit baud code field holds the rate, 115.2 to 1.2k; the shaper only reads it back.
// - Stretched low level covers the receiver's sample points seven to nine.
module infrared_pulse_shaper (
	input wire logic core_clk, // Core clock, 10 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic [infrared_shaper_pkg::APB_ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic baudTick16, // 16x bit-rate enable from the port's timer
	input wire logic serialPortTx, // Transmit line of the serial port
	output logic serialPortRx, // Receive line to the serial port
	output logic uartBTransmitPin, // Transmit pin
	input wire logic uartBReceivePin // Receive pin, asynchronous
);
	import infrared_shaper_pkg::*;

	logic [7:0] ctrlQ;
	logic [3:0] baudCodeQ;
	logic [31:0] prdataQ;
	logic apbAccess;
	logic apbSetup;
	logic ctrlHit;
	logic baudHit;
	logic ctrlWr;
	logic baudWr;
	logic irEn;
	pulse_mode_e pulseMode;
	logic [DIV_W-1:0] divField;
	logic [DIV_W-1:0] divEffM1;
	logic [DIV_W-1:0] divCntQ;
	logic refTick;
	logic rxMetaQ;
	logic rxSyncQ;
	logic rxPrevQ;
	logic rxRise;
	logic txPrevQ;
	logic txFall;
	logic [3:0] phaseQ;
	logic zeroBitNext;
	logic txStart;
	logic [TIMER_W-1:0] minCntQ;
	logic shapedTx;
	logic txPinQ;
	logic rxOutQ;
	logic [7:0] shapedHighQ;
	logic [DIV_W-1:0] gapQ;

	pulse_timer_if #(.W(TIMER_W)) txTmr ();
	pulse_timer_if #(.W(TIMER_W)) rxTmr ();

	////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, error on unmapped address
	assign apbAccess = psel && penable;
	assign apbSetup = psel && !penable;
	assign pready = 1'b1;

	// Address decode
	always_comb
	begin
		ctrlHit = 1'b0;
		baudHit = 1'b0;
		if (paddr == CTRL_ADDR)
		begin
			ctrlHit = 1'b1;
		end
		else if (paddr == BAUD_ADDR)
		begin
			baudHit = 1'b1;
		end
	end

	assign pslverr = apbAccess && !ctrlHit && !baudHit;
	assign ctrlWr = apbAccess && pwrite && ctrlHit && pstrb[0];
	assign baudWr = apbAccess && pwrite && baudHit && pstrb[0];

	// Control register; reserved bit 7 ignores writes and reads zero
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			ctrlQ <= CTRL_RESET;
		end
		else if (ctrlWr)
		begin
			ctrlQ <= pwdata[7:0] & CTRL_WMASK;
		end
	end

	// Baud code register; codes beyond the table are clamped to the slowest rate
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			baudCodeQ <= BAUD_RESET;
		end
		else if (baudWr)
		begin
			if (pwdata[BAUD_MSB:BAUD_LSB] > BAUD_CODE_MAX)
			begin
				baudCodeQ <= BAUD_CODE_MAX;
			end
			else
			begin
				baudCodeQ <= pwdata[BAUD_MSB:BAUD_LSB];
			end
		end
	end

	// Read data captured in the setup phase, so it is steady in the access phase
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			prdataQ <= '0;
		end
		else if (apbSetup && !pwrite)
		begin
			if (ctrlHit)
			begin
				prdataQ <= {24'h000000, ctrlQ};
			end
			else if (baudHit)
			begin
				prdataQ <= {24'h000000, baudCodeQ, 4'h0};
			end
			else
			begin
				prdataQ <= '0;
			end
		end
	end

	assign prdata = prdataQ;

	////////////////////////////////////////////////////////////////
	// Control fields
	assign irEn = ctrlQ[EN_BIT];
	assign pulseMode = pulse_mode_e'(ctrlQ[PULSE_BIT]);
	assign divField = ctrlQ[DIV_MSB:DIV_LSB];
	// A zero divider would stall the reference; treat it as divide by one
	assign divEffM1 = (divField == '0) ? '0 : divField - DIV_W'(1);

	// Reference clock enable: core clock divided by the divider field
	assign refTick = (divCntQ >= divEffM1);
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			divCntQ <= '0;
		end
		else if (ctrlWr || refTick)
		begin
			divCntQ <= '0;
		end
		else
		begin
			divCntQ <= divCntQ + DIV_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive pin synchroniser, then a separate stage for edge detection
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rxMetaQ <= 1'b0;
			rxSyncQ <= 1'b0;
			rxPrevQ <= 1'b0;
		end
		else
		begin
			rxMetaQ <= uartBReceivePin;
			rxSyncQ <= rxMetaQ;
			rxPrevQ <= rxSyncQ;
		end
	end

	assign rxRise = rxSyncQ && !rxPrevQ;

	////////////////////////////////////////////////////////////////
	// Transmit bit tracking: phase restarts on each falling edge of the line,
	// so it stays aligned with the port's own 16x counter
	assign txFall = !serialPortTx && txPrevQ;
	assign zeroBitNext = baudTick16 && (phaseQ == PHASE_LAST) && !serialPortTx;
	assign txStart = irEn && (txFall || zeroBitNext);

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			txPrevQ <= 1'b1;
		end
		else
		begin
			txPrevQ <= serialPortTx;
		end
	end

	// Bit phase in sixteenths
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			phaseQ <= '0;
		end
		else if (txFall)
		begin
			phaseQ <= '0;
		end
		else if (baudTick16)
		begin
			phaseQ <= phaseQ + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit pulse timer: three reference ticks or three sixteenths of a bit
	assign txTmr.start = txStart;
	assign txTmr.length = TX_PULSE_TICKS;
	assign txTmr.tick = (pulseMode == PULSE_PROPORTIONAL) ? baudTick16 : refTick;

	tick_pulse_timer #(.W(TIMER_W)) txTimer (
		.core_clk(core_clk),
		.rstn(rstn),
		.tmr(txTmr)
	);

	// Floor on width: a badly chosen divider cannot make a too narrow pulse;
	// the upper bound stays with the divider choice
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			minCntQ <= '0;
		end
		else if (txStart)
		begin
			minCntQ <= TIMER_W'(MIN_PULSE_CYC);
		end
		else if (minCntQ != '0)
		begin
			minCntQ <= minCntQ - TIMER_W'(1);
		end
	end

	assign shapedTx = txTmr.busy || (minCntQ != '0);

	// Transmit pin mux, registered so the pin never glitches
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			txPinQ <= 1'b1;
		end
		else if (irEn)
		begin
			txPinQ <= shapedTx;
		end
		else
		begin
			txPinQ <= serialPortTx;
		end
	end

	assign uartBTransmitPin = txPinQ;

	////////////////////////////////////////////////////////////////
	// Receive stretcher: one full bit period covers the 7th to 9th sample points
	assign rxTmr.start = irEn && rxRise;
	assign rxTmr.length = RX_STRETCH_TICKS;
	assign rxTmr.tick = baudTick16;

	tick_pulse_timer #(.W(TIMER_W)) rxTimer (
		.core_clk(core_clk),
		.rstn(rstn),
		.tmr(rxTmr)
	);

	// Receive line mux towards the port
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rxOutQ <= 1'b1;
		end
		else if (irEn)
		begin
			rxOutQ <= !(rxTmr.busy || rxTmr.start);
		end
		else
		begin
			rxOutQ <= rxSyncQ;
		end
	end

	assign serialPortRx = rxOutQ;

	////////////////////////////////////////////////////////////////
	// Helpers read only by checks
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			shapedHighQ <= '0;
		end
		else if (!shapedTx)
		begin
			shapedHighQ <= '0;
		end
		else if (shapedHighQ != 8'hFF)
		begin
			shapedHighQ <= shapedHighQ + 8'h01;
		end
	end

	// Cycles since the last reference tick
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			gapQ <= '0;
		end
		else if (ctrlWr || refTick)
		begin
			gapQ <= '0;
		end
		else
		begin
			gapQ <= gapQ + DIV_W'(1);
		end
	end

	sequence txZeroStart;
		irEn && !serialPortTx && txPrevQ;
	endsequence

	sequence rxPulseSeen;
		irEn && rxRise;
	endsequence

	AST_RESET_CTRL: assert property (@(posedge core_clk)
		$rose(rstn) |-> (ctrlQ == CTRL_RESET) && !irEn)
		else $error("Control register not at reset value after reset");

	AST_TX_BYPASS: assert property (@(posedge core_clk) disable iff (!rstn)
		!irEn |=> uartBTransmitPin == $past(serialPortTx))
		else $error("Transmit pin does not follow the port while disabled");

	AST_RX_BYPASS: assert property (@(posedge core_clk) disable iff (!rstn)
		!irEn |=> serialPortRx == $past(rxSyncQ))
		else $error("Receive line does not follow the pin while disabled");

	AST_TX_ONE_SILENT: assert property (@(posedge core_clk) disable iff (!rstn)
		irEn && serialPortTx && !shapedTx |=> !shapedTx)
		else $error("Pulse started while the transmit line is high");

	AST_TX_ZERO_PULSE: assert property (@(posedge core_clk) disable iff (!rstn)
		txZeroStart |-> ##[1:2] (uartBTransmitPin || !irEn))
		else $error("Zero bit gave no pulse on the transmit pin");

	AST_RX_STRETCH: assert property (@(posedge core_clk) disable iff (!rstn)
		rxPulseSeen |=> (!serialPortRx || !irEn) ##1 (!serialPortRx || !irEn))
		else $error("Received pulse not stretched to a low level");

	AST_MIN_WIDTH: assert property (@(posedge core_clk) disable iff (!rstn)
		$fell(shapedTx) |-> shapedHighQ >= MIN_PULSE_CYC)
		else $error("Transmitted pulse shorter than the minimum width");

	AST_REF_PERIOD: assert property (@(posedge core_clk) disable iff (!rstn)
		refTick |-> (8'(gapQ) + 8'h01) == ((divField == '0) ? 8'h01 : 8'(divField)))
		else $error("Reference tick spacing differs from the divider");

endmodule // infrared_pulse_shaper

`default_nettype wire

// ### verilog/infrared_shaper_pkg.sv
// Constants shared by the infrared pulse shaper and its timers
`default_nettype none

package infrared_shaper_pkg;

	// APB decode: printed offsets are register indexes, byte address is four times that
	localparam int APB_ADDR_W = 12;
	localparam logic [7:0] CTRL_IDX = 8'hCE;
	localparam logic [7:0] BAUD_IDX = 8'hCF;
	localparam logic [APB_ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [APB_ADDR_W-1:0] BAUD_ADDR = {2'h0, BAUD_IDX, 2'h0};

	// Control register layout and reset value
	localparam logic [7:0] CTRL_RESET = 8'h0F;
	localparam int EN_BIT = 6;
	localparam int PULSE_BIT = 5;
	localparam int DIV_MSB = 4;
	localparam int DIV_LSB = 0;
	localparam int DIV_W = DIV_MSB - DIV_LSB + 1;
	localparam logic [7:0] CTRL_WMASK = 8'h7F;

	// Baud select register: code in the upper nibble
	localparam int BAUD_MSB = 7;
	localparam int BAUD_LSB = 4;
	localparam logic [3:0] BAUD_RESET = 4'h0;
	localparam logic [3:0] BAUD_CODE_MAX = 4'hC;

	// Pulse mode encoding of the pulse-mode bit
	typedef enum logic {
		PULSE_FIXED = 1'b0,
		PULSE_PROPORTIONAL = 1'b1
	} pulse_mode_e;

	// Timer widths and tick counts
	localparam int TIMER_W = 5;
	localparam logic [TIMER_W-1:0] TX_PULSE_TICKS = 5'h03;
	localparam logic [TIMER_W-1:0] RX_STRETCH_TICKS = 5'h10;
	localparam logic [3:0] PHASE_LAST = 4'hF;

	// Timing in nanoseconds at the core clock rate
	localparam int CLK_PERIOD_NS = 100;
	localparam int MIN_PULSE_NS = 1410;
	localparam int MAX_PULSE_NS = 2230;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_PULSE_CYC = MAX_PULSE_NS / CLK_PERIOD_NS;

endpackage : infrared_shaper_pkg

`default_nettype wire

// ### verilog/pulse_timer_if.sv
// Start, tick and busy signals between the shaper and one pulse timer
`default_nettype none

interface pulse_timer_if #(
	parameter int W = 5
);
	logic start;
	logic tick;
	logic [W-1:0] length;
	logic busy;

	modport ctrl (output start, output tick, output length, input busy);
	modport timer (input start, input tick, input length, output busy);
endinterface : pulse_timer_if

`default_nettype wire

// ### verilog/tick_pulse_timer.sv
// Retriggerable timer that stays busy for a number of enable ticks
`default_nettype none

module tick_pulse_timer #(
	parameter int W = 5
) (
	input wire logic core_clk, // Core clock
	input wire logic rstn, // Synchronous reset, active low
	pulse_timer_if.timer tmr // Start, tick, length and busy
);
	import infrared_shaper_pkg::*;

	logic [W-1:0] remainQ;
	logic busyQ;
	logic [W-1:0] lenQ;
	logic [W-1:0] ticksSeenQ;

	assign tmr.busy = busyQ;

	////////////////////////////////////////////////////////////////
	// Countdown; a new start wins over the last tick so a pulse is never lost
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			remainQ <= '0;
			busyQ <= 1'b0;
		end
		else if (tmr.start)
		begin
			remainQ <= tmr.length;
			busyQ <= (tmr.length != '0);
		end
		else if (busyQ && tmr.tick)
		begin
			remainQ <= remainQ - W'(1);
			busyQ <= (remainQ != W'(1));
		end
	end

	////////////////////////////////////////////////////////////////
	// Helper: ticks seen while busy, for the width check
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			lenQ <= '0;
			ticksSeenQ <= '0;
		end
		else if (tmr.start)
		begin
			lenQ <= tmr.length;
			ticksSeenQ <= '0;
		end
		else if (busyQ && tmr.tick)
		begin
			ticksSeenQ <= ticksSeenQ + W'(1);
		end
	end

	AST_TICK_COUNT: assert property (@(posedge core_clk) disable iff (!rstn)
		$fell(busyQ) |-> ticksSeenQ == lenQ)
		else $error("Pulse timer ended after the wrong number of ticks");

endmodule // tick_pulse_timer

`default_nettype wire
